// ### logic/bpb_port_block.sv
// three-port general-purpose I/O: two 8-line ports and one 1-line port
// assumes the core gives a one-cycle access strobe, a second-phase strobe for reads,
// a level low-power flag, a reset-kind flag and per-pin function selects
`timescale 1ns/10ps

module bpb_port_block #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic                   clk_sys_i,
    input  wire logic                   arst_n_i,
    input  wire logic                   clk_en_i,
    input  wire bpb_pkg::bpb_access_type acc_i,
    input  wire logic                   second_clock_phase_i,
    input  wire logic                   low_power_i,
    input  wire logic                   soft_reset_i,
    input  wire logic                   soft_reset_keep_i,
    input  wire logic [WIDTH-1:0]       gpio_sel_a_i,
    input  wire logic [WIDTH-1:0]       gpio_sel_b_i,
    input  wire logic                   gpio_sel_c_i,
    input  wire logic [WIDTH-1:0]       pin_a_i,
    input  wire logic [WIDTH-1:0]       pin_b_i,
    input  wire logic                   pin_c_i,
    output logic      [WIDTH-1:0]       pin_a_o,
    output logic      [WIDTH-1:0]       pin_a_oe_o,
    output logic      [WIDTH-1:0]       pin_a_pull_o,
    output logic      [WIDTH-1:0]       pin_b_o,
    output logic      [WIDTH-1:0]       pin_b_oe_o,
    output logic      [WIDTH-1:0]       pin_b_pull_o,
    output logic                        pin_c_o,
    output logic                        pin_c_oe_o,
    output logic                        pin_c_pull_o,
    output logic      [7:0]             rdata_o,
    output logic                        wake_o
);
    logic             rst_meta_reg;
    logic             rst_n_reg;
    logic [WIDTH-1:0] a_data_reg, a_dir_reg, a_pu_reg, a_wu_reg;
    logic [WIDTH-1:0] b_data_reg, b_dir_reg, b_pu_reg;
    logic             c_data_reg, c_dir_reg, c_pu_reg;
    logic [WIDTH-1:0] a_meta_reg, a_sync_reg, a_prev_reg;
    logic [WIDTH-1:0] b_meta_reg, b_sync_reg;
    logic             c_meta_reg, c_sync_reg;
    bpb_pkg::bpb_mode_type mode_reg;

    // reset release through two flops
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge clk_sys_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            a_meta_reg <= '1;
            a_sync_reg <= '1;
            a_prev_reg <= '1;
            b_meta_reg <= '1;
            b_sync_reg <= '1;
            c_meta_reg <= 1'b1;
            c_sync_reg <= 1'b1;
        end else if (clk_en_i) begin
            a_meta_reg <= pin_a_i;
            a_sync_reg <= a_meta_reg;
            a_prev_reg <= a_sync_reg;
            b_meta_reg <= pin_b_i;
            b_sync_reg <= b_meta_reg;
            c_meta_reg <= pin_c_i;
            c_sync_reg <= c_meta_reg;
        end
    end

    wire wr_a_data = acc_i.wr && acc_i.addr == bpb_pkg::IDX_PORT_A_DATA;
    wire wr_a_dir  = acc_i.wr && acc_i.addr == bpb_pkg::IDX_PORT_A_DIRECTION;
    wire wr_a_pu   = acc_i.wr && acc_i.addr == bpb_pkg::IDX_PORT_A_PULLUP;
    wire wr_a_wu   = acc_i.wr && acc_i.addr == bpb_pkg::IDX_PORT_A_WAKE;
    wire wr_b_data = acc_i.wr && acc_i.addr == bpb_pkg::IDX_PORT_B_DATA;
    wire wr_b_dir  = acc_i.wr && acc_i.addr == bpb_pkg::IDX_PORT_B_DIRECTION;
    wire wr_b_pu   = acc_i.wr && acc_i.addr == bpb_pkg::IDX_PORT_B_PULLUP;
    wire wr_c_data = acc_i.wr && acc_i.addr == bpb_pkg::IDX_PORT_C_DATA;
    wire wr_c_dir  = acc_i.wr && acc_i.addr == bpb_pkg::IDX_PORT_C_DIRECTION;
    wire wr_c_pu   = acc_i.wr && acc_i.addr == bpb_pkg::IDX_PORT_C_PULLUP;
    // a watchdog reset while dozing leaves every port register untouched
    wire soft_init = soft_reset_i && !soft_reset_keep_i;

    always_ff @(posedge clk_sys_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            a_data_reg <= bpb_pkg::RST_DATA;
            a_dir_reg  <= bpb_pkg::RST_DIRECTION;
            a_pu_reg   <= bpb_pkg::RST_PULLUP;
            a_wu_reg   <= bpb_pkg::RST_WAKE;
            b_data_reg <= bpb_pkg::RST_DATA;
            b_dir_reg  <= bpb_pkg::RST_DIRECTION;
            b_pu_reg   <= bpb_pkg::RST_PULLUP;
            c_data_reg <= 1'b1;
            c_dir_reg  <= 1'b1;
            c_pu_reg   <= 1'b0;
        end else if (clk_en_i) begin
            if (soft_init) begin
                a_data_reg <= bpb_pkg::RST_DATA;
                a_dir_reg  <= bpb_pkg::RST_DIRECTION;
                a_pu_reg   <= bpb_pkg::RST_PULLUP;
                a_wu_reg   <= bpb_pkg::RST_WAKE;
                b_data_reg <= bpb_pkg::RST_DATA;
                b_dir_reg  <= bpb_pkg::RST_DIRECTION;
                b_pu_reg   <= bpb_pkg::RST_PULLUP;
                c_data_reg <= 1'b1;
                c_dir_reg  <= 1'b1;
                c_pu_reg   <= 1'b0;
            end else begin
                if (wr_a_data) a_data_reg <= acc_i.wdata;
                if (wr_a_dir)  a_dir_reg  <= acc_i.wdata;
                if (wr_a_pu)   a_pu_reg   <= acc_i.wdata;
                if (wr_a_wu)   a_wu_reg   <= acc_i.wdata;
                if (wr_b_data) b_data_reg <= acc_i.wdata;
                if (wr_b_dir)  b_dir_reg  <= acc_i.wdata;
                if (wr_b_pu)   b_pu_reg   <= acc_i.wdata;
                if (wr_c_data) c_data_reg <= acc_i.wdata[0];
                if (wr_c_dir)  c_dir_reg  <= acc_i.wdata[0];
                if (wr_c_pu)   c_pu_reg   <= acc_i.wdata[0];
            end
        end
    end

    // per-line read value: pin when input, latch when output
    wire [WIDTH-1:0] a_view = (a_dir_reg & a_sync_reg) | (~a_dir_reg & a_data_reg);
    wire [WIDTH-1:0] b_view = (b_dir_reg & b_sync_reg) | (~b_dir_reg & b_data_reg);
    wire             c_view = c_dir_reg ? c_sync_reg : c_data_reg;

    logic [7:0] rd_mux;
    always_comb begin
        case (acc_i.addr)
            bpb_pkg::IDX_PORT_A_DATA:      rd_mux = a_view;
            bpb_pkg::IDX_PORT_A_DIRECTION: rd_mux = a_dir_reg;
            bpb_pkg::IDX_PORT_A_PULLUP:    rd_mux = a_pu_reg;
            bpb_pkg::IDX_PORT_A_WAKE:      rd_mux = a_wu_reg;
            bpb_pkg::IDX_PORT_B_DATA:      rd_mux = b_view;
            bpb_pkg::IDX_PORT_B_DIRECTION: rd_mux = b_dir_reg;
            bpb_pkg::IDX_PORT_B_PULLUP:    rd_mux = b_pu_reg;
            bpb_pkg::IDX_PORT_C_DATA:      rd_mux = {7'h00, c_view};
            bpb_pkg::IDX_PORT_C_DIRECTION: rd_mux = {7'h00, c_dir_reg};
            bpb_pkg::IDX_PORT_C_PULLUP:    rd_mux = {7'h00, c_pu_reg};
            default:                       rd_mux = 8'h00;
        endcase
    end

    // pin drive and pull-high, pull only on a selected digital input line
    wire [WIDTH-1:0] a_pull_next = a_pu_reg & a_dir_reg & gpio_sel_a_i;
    wire [WIDTH-1:0] b_pull_next = b_pu_reg & b_dir_reg & gpio_sel_b_i;
    wire             c_pull_next = c_pu_reg & c_dir_reg & gpio_sel_c_i;
    // falling edges on enabled general-input first-port lines
    wire [WIDTH-1:0] a_fall = a_prev_reg & ~a_sync_reg & a_wu_reg & a_dir_reg & gpio_sel_a_i;
    wire             dozing = mode_reg == bpb_pkg::BPB_DOZE;
    wire             wake_next = dozing && low_power_i && (|a_fall);

    bpb_pkg::bpb_mode_type mode_next;
    always_comb begin
        case (mode_reg)
            bpb_pkg::BPB_RUN:  mode_next = low_power_i ? bpb_pkg::BPB_DOZE : bpb_pkg::BPB_RUN;
            bpb_pkg::BPB_DOZE: mode_next = low_power_i ? bpb_pkg::BPB_DOZE : bpb_pkg::BPB_RUN;
            default:           mode_next = bpb_pkg::BPB_RUN;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            mode_reg     <= bpb_pkg::BPB_RUN;
            rdata_o      <= 8'h00;
            wake_o       <= 1'b0;
            pin_a_o      <= '1;
            pin_a_oe_o   <= '0;
            pin_a_pull_o <= '0;
            pin_b_o      <= '1;
            pin_b_oe_o   <= '0;
            pin_b_pull_o <= '0;
            pin_c_o      <= 1'b1;
            pin_c_oe_o   <= 1'b0;
            pin_c_pull_o <= 1'b0;
        end else if (clk_en_i) begin
            mode_reg <= mode_next;
            wake_o   <= wake_next;
            // no read latch: value captured only at the second phase edge
            if (acc_i.rd && second_clock_phase_i) rdata_o <= rd_mux;
            pin_a_o      <= a_data_reg;
            pin_a_oe_o   <= ~a_dir_reg;
            pin_a_pull_o <= a_pull_next;
            pin_b_o      <= b_data_reg;
            pin_b_oe_o   <= ~b_dir_reg;
            pin_b_pull_o <= b_pull_next;
            pin_c_o      <= c_data_reg;
            pin_c_oe_o   <= ~c_dir_reg;
            pin_c_pull_o <= c_pull_next;
        end
    end

    oe_follows_dir_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        clk_en_i |=> pin_a_oe_o == ~$past(a_dir_reg))
        else $error("port a drive enable does not follow direction");
    drive_latch_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        clk_en_i |=> pin_b_o == $past(b_data_reg))
        else $error("port b drive differs from latch");
    read_view_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        (clk_en_i && acc_i.rd && second_clock_phase_i && acc_i.addr == bpb_pkg::IDX_PORT_A_DATA)
        |=> rdata_o == (($past(a_dir_reg) & $past(a_sync_reg)) | (~$past(a_dir_reg) & $past(a_data_reg))))
        else $error("port a read value wrong");
    latch_hold_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        (!wr_a_data && !soft_init) |=> $stable(a_data_reg))
        else $error("port a latch changed without write");
    pull_gate_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        (clk_en_i && !a_dir_reg[0]) |=> !pin_a_pull_o[0])
        else $error("pull-high on an output line");
    wake_mode_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        (clk_en_i && !low_power_i) |=> !wake_o)
        else $error("wake outside low power");
    port_c_zero_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        (clk_en_i && acc_i.rd && second_clock_phase_i && acc_i.addr == bpb_pkg::IDX_PORT_C_PULLUP)
        |=> rdata_o[7:1] == 7'h00)
        else $error("port c upper bits not zero");
    soft_reset_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        (clk_en_i && soft_init) |=> a_dir_reg == bpb_pkg::RST_DIRECTION && a_wu_reg == 8'h00)
        else $error("soft reset did not load values");
    keep_reset_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        (soft_reset_i && soft_reset_keep_i && !acc_i.wr) |=> $stable(b_dir_reg))
        else $error("low-power watchdog reset changed port");

    // pin-side outputs trail their registers by exactly one enabled edge
    oe_follow_b_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        clk_en_i |=> pin_b_oe_o == ~$past(b_dir_reg))
        else $error("port b drive enable does not follow direction");
    oe_follow_c_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        clk_en_i |=> pin_c_oe_o == !$past(c_dir_reg))
        else $error("port c drive enable does not follow direction");
    latch_drive_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        clk_en_i |=> pin_a_o == $past(a_data_reg))
        else $error("port a drive differs from latch");
    latch_drive_c_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        clk_en_i |=> pin_c_o == $past(c_data_reg))
        else $error("port c drive differs from latch");

    read_view_b_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        (clk_en_i && acc_i.rd && second_clock_phase_i && acc_i.addr == bpb_pkg::IDX_PORT_B_DATA)
        |=> rdata_o == (($past(b_dir_reg) & $past(b_sync_reg)) | (~$past(b_dir_reg) & $past(b_data_reg))))
        else $error("port b read value wrong");
    read_view_c_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        (clk_en_i && acc_i.rd && second_clock_phase_i && acc_i.addr == bpb_pkg::IDX_PORT_C_DATA)
        |=> rdata_o == {7'h00, ($past(c_dir_reg) ? $past(c_sync_reg) : $past(c_data_reg))})
        else $error("port c read value wrong");
    read_hold_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        !(clk_en_i && acc_i.rd && second_clock_phase_i) |=> $stable(rdata_o))
        else $error("read data moved without a captured read");
    unmapped_read_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        (clk_en_i && acc_i.rd && second_clock_phase_i && acc_i.addr > bpb_pkg::IDX_PORT_C_PULLUP)
        |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");

    latch_hold_b_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        (!wr_b_data && !soft_init) |=> $stable(b_data_reg))
        else $error("port b latch changed without write");
    dir_write_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        (clk_en_i && wr_a_dir && !soft_init) |=> a_dir_reg == $past(acc_i.wdata))
        else $error("port a direction write lost");
    pull_follow_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        clk_en_i |=> pin_a_pull_o == $past(a_pu_reg & a_dir_reg & gpio_sel_a_i))
        else $error("port a pull-high does not follow its enable");
    pull_gate_b_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        clk_en_i |=> (pin_b_pull_o & ~$past(b_dir_reg & gpio_sel_b_i)) == '0)
        else $error("port b pull-high on a non-input line");
    pull_gate_c_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        clk_en_i |=> !(pin_c_pull_o && !$past(c_dir_reg && gpio_sel_c_i)))
        else $error("port c pull-high on a non-input line");

    // wake-up: a missed edge leaves the core asleep, a false one costs power
    wake_edge_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        (clk_en_i && dozing && low_power_i
            && (|(a_prev_reg & ~a_sync_reg & a_wu_reg & a_dir_reg & gpio_sel_a_i))) |=> wake_o)
        else $error("enabled falling edge did not wake");
    wake_enable_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        (clk_en_i && a_wu_reg == '0) |=> !wake_o)
        else $error("wake with no line enabled");
    wake_select_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        (clk_en_i && (a_wu_reg & a_dir_reg & gpio_sel_a_i) == '0) |=> !wake_o)
        else $error("wake from a line that is not a general input");
    freeze_hold_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        !clk_en_i |=> $stable(a_data_reg) && $stable(b_dir_reg) && $stable(mode_reg)
            && $stable(pin_a_o) && $stable(rdata_o) && $stable(wake_o))
        else $error("state moved while the clock enable was low");
    sync_stage_a : assert property (@(posedge clk_sys_i) disable iff (!rst_n_reg)
        clk_en_i |=> a_sync_reg == $past(a_meta_reg) && b_sync_reg == $past(b_meta_reg))
        else $error("pin synchroniser skipped a stage");
endmodule

// ### logic/bpb_pkg.sv
// package for the bidirectional port block: register indices, reset values, shared types
// assumes the core addresses the port registers as data-memory locations of its own choosing
package bpb_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] IDX_PORT_A_DATA      = 8'h00;
    localparam logic [7:0] IDX_PORT_A_DIRECTION = 8'h01;
    localparam logic [7:0] IDX_PORT_A_PULLUP    = 8'h02;
    localparam logic [7:0] IDX_PORT_A_WAKE      = 8'h03;
    localparam logic [7:0] IDX_PORT_B_DATA      = 8'h04;
    localparam logic [7:0] IDX_PORT_B_DIRECTION = 8'h05;
    localparam logic [7:0] IDX_PORT_B_PULLUP    = 8'h06;
    localparam logic [7:0] IDX_PORT_C_DATA      = 8'h07;
    localparam logic [7:0] IDX_PORT_C_DIRECTION = 8'h08;
    localparam logic [7:0] IDX_PORT_C_PULLUP    = 8'h09;
    localparam logic [7:0] RST_DATA      = 8'hFF;
    localparam logic [7:0] RST_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_PULLUP    = 8'h00;
    localparam logic [7:0] RST_WAKE      = 8'h00;
    localparam logic [7:0] PORT_C_MASK   = 8'h01;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bpb_access_type;

    typedef enum logic [1:0] {
        BPB_RUN   = 2'b01,
        BPB_DOZE  = 2'b10
    } bpb_mode_type;
endpackage

// ### bench/bpb_pin_world.sv
// board model for one port: switches that can overpower a line, LEDs, floating lines
// assumes the port drives drv_i onto the pin while oe_i is high
`timescale 1ns/10ps
module bpb_pin_world #(
    parameter int unsigned W = 8
) (
    input  wire logic         clk_sys_i,
    input  wire logic [W-1:0] drv_i,
    input  wire logic [W-1:0] oe_i,
    input  wire logic [W-1:0] pull_i,
    input  wire logic [W-1:0] sw_en_i,
    input  wire logic [W-1:0] sw_lvl_i,
    output logic      [W-1:0] pin_o
);
    logic [W-1:0] drift_reg = '0;
    // an undriven, unpulled line wanders so no stale level can pass a check
    always @(posedge clk_sys_i) drift_reg <= ~drift_reg;
    // a closed switch wins even over a driven line, so pin and latch can differ
    assign pin_o = (sw_en_i & sw_lvl_i) | (~sw_en_i & oe_i & drv_i)
                 | (~sw_en_i & ~oe_i & (pull_i | drift_reg));
endmodule

// ### bench/tb_bpb_port_block.sv
// self-checking bench for the three-port I/O block
// assumes the board model above on every port; registers reached through acc_i
`timescale 1ns/10ps
module tb_bpb_port_block;
    logic clk_sys_i = 1'b0;
    logic arst_n_i  = 1'b0;
    bpb_pkg::bpb_access_type acc = '0;
    logic       phase = 1'b0, low_pw = 1'b0, srst = 1'b0, skeep = 1'b0, cen = 1'b1;
    logic [7:0] sel_a = 8'hFF, sel_b = 8'hFF, sw_en_a = 8'hFF, sw_a = 8'h00;
    logic [7:0] sw_en_b = 8'hFF, sw_b = 8'h00;
    logic       sw_en_c = 1'b1, sw_c = 1'b0;
    logic [7:0] a_pin, a_drv, a_oe, a_pull, b_pin, b_drv, b_oe, b_pull, rdata;
    logic       c_pin, c_drv, c_oe, c_pull, wake;
    int         error_cnt = 0;
    int         compares  = 0;
    logic [7:0] rst_exp [10] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00,
                                 8'h00, 8'h01, 8'h00};

    always #2 clk_sys_i = ~clk_sys_i;

    bpb_port_block dut_u (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .clk_en_i(cen),
        .acc_i(acc), .second_clock_phase_i(phase), .low_power_i(low_pw),
        .soft_reset_i(srst), .soft_reset_keep_i(skeep), .gpio_sel_a_i(sel_a),
        .gpio_sel_b_i(sel_b), .gpio_sel_c_i(1'b1), .pin_a_i(a_pin), .pin_b_i(b_pin),
        .pin_c_i(c_pin), .pin_a_o(a_drv), .pin_a_oe_o(a_oe), .pin_a_pull_o(a_pull),
        .pin_b_o(b_drv), .pin_b_oe_o(b_oe), .pin_b_pull_o(b_pull), .pin_c_o(c_drv),
        .pin_c_oe_o(c_oe), .pin_c_pull_o(c_pull), .rdata_o(rdata), .wake_o(wake));
    bpb_pin_world #(.W(8)) world_a (.clk_sys_i(clk_sys_i), .drv_i(a_drv), .oe_i(a_oe),
        .pull_i(a_pull), .sw_en_i(sw_en_a), .sw_lvl_i(sw_a), .pin_o(a_pin));
    bpb_pin_world #(.W(8)) world_b (.clk_sys_i(clk_sys_i), .drv_i(b_drv), .oe_i(b_oe),
        .pull_i(b_pull), .sw_en_i(sw_en_b), .sw_lvl_i(sw_b), .pin_o(b_pin));
    bpb_pin_world #(.W(1)) world_c (.clk_sys_i(clk_sys_i), .drv_i(c_drv), .oe_i(c_oe),
        .pull_i(c_pull), .sw_en_i(sw_en_c), .sw_lvl_i(sw_c), .pin_o(c_pin));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // strobe lowered, then one idle cycle so back-to-back calls never re-drive in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc.wr = 1'b1; acc.addr = a; acc.wdata = d;
        @(negedge clk_sys_i);
        acc.wr = 1'b0;
        @(negedge clk_sys_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        acc.rd = 1'b1; acc.addr = a; phase = 1'b1;
        @(negedge clk_sys_i);
        acc.rd = 1'b0; phase = 1'b0;
        chk(what, rdata, exp);
        @(negedge clk_sys_i);
    endtask
    task automatic settle();
        repeat (4) @(negedge clk_sys_i);
    endtask
    task automatic wake_cnt(input int exp, input string what);
        int n;
        n = 0;
        repeat (12) begin
            @(negedge clk_sys_i);
            if (wake !== 1'b0) n++;
        end
        chk(what, 8'(n), 8'(exp));
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic s_reset();
        for (int i = 0; i < 10; i++) rd(8'(i), rst_exp[i], "reset reg");
        chk("oe after reset", a_oe | b_oe | {7'h00, c_oe}, 8'h00);
        chk("drive after reset", a_drv & b_drv & {7'h7F, c_drv}, 8'hFF);
        chk("pull after reset", a_pull | b_pull | {7'h00, c_pull}, 8'h00);
    endtask
    task automatic s_output();
        wr(bpb_pkg::IDX_PORT_A_DIRECTION, 8'h00);
        settle();
        chk("drive A", a_oe & a_drv, 8'hFF);
        rd(bpb_pkg::IDX_PORT_A_DATA, 8'hFF, "latch A");
        wr(bpb_pkg::IDX_PORT_A_DATA, 8'h5A);
        rd(bpb_pkg::IDX_PORT_A_DATA, 8'h5A, "latch A");
        chk("pins A", a_drv, 8'h5A);
        wr(bpb_pkg::IDX_PORT_A_DIRECTION, 8'hFF);
        settle();
        rd(bpb_pkg::IDX_PORT_A_DATA, 8'h00, "live A");
        wr(bpb_pkg::IDX_PORT_A_DIRECTION, 8'h00);
        rd(bpb_pkg::IDX_PORT_A_DATA, 8'h5A, "held A");
        wr(bpb_pkg::IDX_PORT_A_DIRECTION, 8'hFF);
    endtask
    task automatic s_input();
        sw_b = 8'h3C;
        settle();
        rd(bpb_pkg::IDX_PORT_B_DATA, 8'h3C, "live B");
        sw_b = 8'hC3;
        settle();
        rd(bpb_pkg::IDX_PORT_B_DATA, 8'hC3, "live B");
    endtask
    task automatic s_pull();
        sw_en_b = 8'h00; sel_b = 8'h0F;
        wr(bpb_pkg::IDX_PORT_B_PULLUP, 8'h7F);
        wr(bpb_pkg::IDX_PORT_B_DIRECTION, 8'h33);
        settle();
        chk("pull B", b_pull, 8'h03);
        chk("oe B", b_oe, 8'hCC);
        rd(bpb_pkg::IDX_PORT_B_PULLUP, 8'h7F, "pull reg B");
        wr(bpb_pkg::IDX_PORT_C_PULLUP, 8'hFF);
        wr(bpb_pkg::IDX_PORT_C_DATA, 8'hFF);
        sw_c = 1'b1;
        settle();
        rd(bpb_pkg::IDX_PORT_C_PULLUP, 8'h01, "pull reg C");
        rd(bpb_pkg::IDX_PORT_C_DATA, 8'h01, "data C");
        chk("pull C", {7'h00, c_pull}, 8'h01);
        rd(8'h0A, 8'h00, "unmapped");
    endtask
    task automatic s_wake();
        sw_a = 8'hFF;
        wr(bpb_pkg::IDX_PORT_A_WAKE, 8'h08);
        low_pw = 1'b1;
        settle();
        sw_a = 8'hF7;
        wake_cnt(1, "wake line 3");
        sw_a = 8'hFF;
        settle();
        sw_a = 8'hEF;
        wake_cnt(0, "wake line 4");
        low_pw = 1'b0; sw_a = 8'hFF;
        settle();
        sw_a = 8'hF7;
        wake_cnt(0, "wake awake");
        sw_a = 8'hFF;
        sel_a = 8'hF7;
        low_pw = 1'b1;
        settle();
        sw_a = 8'hF7;
        wake_cnt(0, "wake shared pin");
        low_pw = 1'b0;
        sel_a = 8'hFF;
        sw_a = 8'hFF;
    endtask
    // with the enable low neither the write nor the read may take effect
    task automatic s_freeze();
        cen = 1'b0;
        wr(bpb_pkg::IDX_PORT_A_DATA, 8'hC3);
        rd(bpb_pkg::IDX_PORT_A_DIRECTION, 8'h00, "frozen read");
        cen = 1'b1;
        settle();
        chk("frozen latch", a_drv, 8'h5A);
    endtask
    task automatic s_soft();
        skeep = 1'b1; srst = 1'b1;
        @(negedge clk_sys_i);
        srst = 1'b0;
        @(negedge clk_sys_i);
        rd(bpb_pkg::IDX_PORT_A_WAKE, 8'h08, "kept wake");
        skeep = 1'b0; srst = 1'b1;
        @(negedge clk_sys_i);
        srst = 1'b0;
        @(negedge clk_sys_i);
        rd(bpb_pkg::IDX_PORT_A_WAKE, 8'h00, "cleared wake");
        rd(bpb_pkg::IDX_PORT_B_DIRECTION, 8'hFF, "dir B");
        chk("latch after soft", a_drv, 8'hFF);
    endtask

    initial begin
        repeat (12) @(negedge clk_sys_i);
        arst_n_i = 1'b1;
        // two edges of reset release, then two more before the synchronised pins are real
        repeat (5) @(negedge clk_sys_i);
        s_reset();
        s_output();
        s_input();
        s_pull();
        s_wake();
        s_freeze();
        s_soft();
        give_verdict();
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        #20000;
        error_cnt++;
        give_verdict();
    end
endmodule
